// ---- dv/sfic_board_model.sv ----
// Purpose: far side of the conditioning block: supply levels and dual pins
// Assumes: bench sets supply codes and pin drive just after a clock edge
// Notes: a released pin without pull-down wanders every cycle
module sfic_board_model
   import sfic_pkg::*;
(
   input wire logic clk,
   input wire logic [NDET*CODE_W-1:0] lvl,
   input wire logic [NDUAL-1:0] drv,
   input wire logic [NDUAL-1:0] oe,
   input wire logic [NDUAL-1:0] pd_en,
   output logic [NDET*CODE_W-1:0] sense_code,
   output logic [NDUAL-1:0] vx_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NDUAL-1:0] float_r = '0;
   // floating level flips so a stale value never looks driven
   always @(posedge clk) begin
      float_r <= ~float_r;
   end
   // supply levels reach the detectors unchanged
   assign sense_code = lvl;
   // driven pin wins, a released pin sinks only through the pull-down
   always_comb begin
      for (int j = 0; j < NDUAL; j++) begin
         vx_pin[j] = oe[j] ? drv[j] : (pd_en[j] ? 1'b0 : float_r[j]);
      end
   end
endmodule // sfic_board_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the supply fault input conditioning block
// Assumes: short filter and pulse caps so waits stay brief
// Notes: settle waits follow the fixed path latency of about seven cycles plus filter
module testbench
   import sfic_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int FMAX = 20;
   logic clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, warn_any;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   logic [NDET*CODE_W-1:0] lvl, sense_code;
   logic [NDUAL-1:0] drv, oe, vx_pin, warn_o, logic_o, pd_en;
   logic [NDET-1:0] fault_o;
   logic [NPRI*RNG_W-1:0] range_sel;
   int failures, n_tests, cycles;

   sfic_top #(.FILT_MAX(FMAX), .PULSE_MAX(FMAX)) sfic_top_inst (.clk(clk), .rstn(rstn),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .sense_code(sense_code), .vx_pin(vx_pin), .fault_o(fault_o), .warn_o(warn_o),
      .warn_any_o(warn_any), .logic_o(logic_o), .pulldown_en_o(pd_en),
      .range_sel_o(range_sel));
   sfic_board_model sfic_board_model_inst (.clk(clk), .lvl(lvl), .drv(drv), .oe(oe),
      .pd_en(pd_en), .sense_code(sense_code), .vx_pin(vx_pin));

   // closing report and verdict
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // value compare
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_wdat <= d;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      r = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      chk_reg(r, e);
   endtask

   // count cycles an output bit is high
   task automatic hi_cnt(input int n, input bit is_logic, input int b, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         c += is_logic ? int'(logic_o[b]) : int'(fault_o[b]);
      end
   endtask

   // free running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      int c;
      logic e;
      logic [7:0] lv3 [3];
      logic [7:0] hv [4];
      logic hx [4];
      lv3 = '{8'h30, 8'hd0, 8'h90};
      hv = '{8'h7f, 8'h88, 8'h90, 8'h91};
      hx = '{1'b1, 1'b1, 1'b1, 1'b0};
      rstn = 1'b0;
      {wb_cyc, wb_stb, wb_we} = 3'h0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_wdat = 32'h0;
      lvl = {NDET{8'ha0}};
      drv = '0;
      oe = '1;
      failures = 0;
      n_tests = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      // reset values, unmapped place, caps and masks
      rd_chk(8'h00, CTRL_RST);
      rd_chk(8'h04, CNT_RST);
      rd_chk(8'h10, CH_RST);
      rd_chk(8'h24, CH_RST);
      rd_chk(8'hfc, 32'h0);
      wr(8'h04, 32'h0000_3fff);
      rd_chk(8'h04, FMAX);
      wr(8'h04, 32'h0);
      wr(8'h24, 32'h01ff_ffff);
      rd_chk(8'h24, 32'h007f_ffff);
      // every fault mode against low, high and in-range levels
      for (int m = 0; m < 4; m++) begin
         wr(8'h14, {9'h0, 2'(m), 5'h0, 8'hc0, 8'h40});
         for (int k = 0; k < 3; k++) begin
            lvl[15:8] <= lv3[k];
            tick(12);
            e = ((m == 0 || m == 2) && k == 0) || ((m == 1 || m == 2) && k == 1);
            chk_reg(fault_o[1], e);
         end
      end
      // hysteresis at the clear boundary, range select
      wr(8'h10, 32'h0110_0080);
      rd_chk(8'h10, 32'h0110_0080);
      chk_reg(range_sel[1:0], 2'h2);
      for (int k = 0; k < 4; k++) begin
         lvl[7:0] <= hv[k];
         tick(12);
         chk_reg(fault_o[0], hx[k]);
      end
      // glitch filter drops short pulse, delays long one both ways
      lvl[7:0] <= 8'ha0;
      wr(8'h04, FMAX);
      lvl[7:0] <= 8'h70;
      tick(10);
      lvl[7:0] <= 8'ha0;
      hi_cnt(50, 1'b0, 0, c);
      chk_reg(c, 0);
      lvl[7:0] <= 8'h70;
      tick(15);
      chk_reg(fault_o[0], 1'b0);
      tick(20);
      chk_reg(fault_o[0], 1'b1);
      lvl[7:0] <= 8'ha0;
      tick(15);
      chk_reg(fault_o[0], 1'b1);
      tick(20);
      chk_reg(fault_o[0], 1'b0);
      wr(8'h04, 32'h3);
      lvl[7:0] <= 8'h70;
      tick(12);
      chk_reg(fault_o[0], 1'b1);
      lvl[7:0] <= 8'ha0;
      tick(12);
      chk_reg(fault_o[0], 1'b0);
      wr(8'h04, 32'h0);
      // dual input as analog detector, then as logic with a warning
      wr(8'h24, 32'h0000_0085);
      lvl[47:40] <= 8'h10;
      tick(12);
      chk_reg(fault_o[5], 1'b1);
      lvl[7:0] <= 8'h82;
      wr(8'h00, 32'h0000_0401);
      drv[0] <= 1'b1;
      tick(12);
      chk_reg(fault_o[5], 1'b0);
      chk_reg(warn_o, 5'h01);
      chk_reg(warn_any, 1'b1);
      chk_reg(fault_o[0], 1'b0);
      chk_reg(logic_o[0], 1'b1);
      chk_reg(pd_en, 5'h01);
      rd_chk(8'h24, 32'h0100_0085);
      rd_chk(8'h0c, 32'h0010_8400);
      oe[0] <= 1'b0;
      tick(12);
      chk_reg(logic_o[0], 1'b0);
      // edge detection pulses, zero width and filtered bounce
      oe[0] <= 1'b1;
      drv[0] <= 1'b0;
      wr(8'h08, 32'h3);
      wr(8'h00, 32'h0000_0021);
      tick(12);
      drv[0] <= 1'b1;
      hi_cnt(30, 1'b1, 0, c);
      chk_reg(c, 3);
      drv[0] <= 1'b0;
      hi_cnt(30, 1'b1, 0, c);
      chk_reg(c, 3);
      wr(8'h08, 32'h0);
      drv[0] <= 1'b1;
      hi_cnt(30, 1'b1, 0, c);
      chk_reg(c, 1);
      wr(8'h04, FMAX);
      drv[0] <= 1'b0;
      tick(5);
      drv[0] <= 1'b1;
      hi_cnt(60, 1'b1, 0, c);
      chk_reg(c, 0);
      end_of_test();
   end
endmodule // testbench

// ---- rtl/sfic_chan.sv ----
// Purpose: one detector slice: hysteretic threshold compare and glitch filter
// Assumes: code and pin already synchronised to clk
// Notes: len of zero passes the result with one register of delay
module sfic_chan
   import sfic_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   sfic_chan_if.chan ch
);
   typedef struct packed {
      logic uv_f;
      logic ov_f;
      logic q;
      logic [CNT_W-1:0] cnt;
   } sfic_chst_t;

   sfic_chst_t s_r, s_nxt;
   logic [CODE_W:0] hi_clr;
   logic signed [CODE_W+1:0] lo_clr;
   logic raw;

   // clear points widened so hysteresis cannot wrap
   assign hi_clr = {1'b0, ch.uv_th} + {4'h0, ch.hyst};
   assign lo_clr = $signed({2'b00, ch.ov_th}) - $signed({5'h00, ch.hyst});

   // comparator result selected by fault mode or logic use
   always_comb begin
      case (ch.mode)
         SFIC_MODE_UV: raw = s_r.uv_f;
         SFIC_MODE_OV: raw = s_r.ov_f;
         SFIC_MODE_WIN: raw = s_r.uv_f | s_r.ov_f;
         default: raw = 1'b0;
      endcase
      if (ch.logic_use) begin
         raw = ch.pin;
      end
   end

   // hysteresis flags and glitch filter counter
   always_comb begin
      s_nxt = s_r;
      if (!s_r.uv_f) begin
         s_nxt.uv_f = ch.code < ch.uv_th;
      end else begin
         s_nxt.uv_f = !({1'b0, ch.code} > hi_clr);
      end
      if (!s_r.ov_f) begin
         s_nxt.ov_f = ch.code > ch.ov_th;
      end else begin
         s_nxt.ov_f = !($signed({2'b00, ch.code}) < lo_clr);
      end
      if (raw == s_r.q) begin
         s_nxt.cnt = '0;
      end else if ({1'b0, s_r.cnt} + 15'h0001 >= {1'b0, ch.len}) begin
         s_nxt.q = raw;
         s_nxt.cnt = '0;
      end else begin
         s_nxt.cnt = s_r.cnt + 14'h0001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ch.q = s_r.q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_uv_hold;
      s_r.uv_f && ({1'b0, ch.code} <= hi_clr) |=> s_r.uv_f;
   endproperty
   a_uv_hold: assert property (p_uv_hold) else $error("uv flag cleared inside hysteresis");

   property p_ov_hold;
      s_r.ov_f && !($signed({2'b00, ch.code}) < lo_clr) |=> s_r.ov_f;
   endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("ov flag cleared inside hysteresis");

   sequence s_diff3;
      (raw != s_r.q && s_r.cnt == '0 && ch.len == 14'd3) ##1 (raw != s_r.q)[*2];
   endsequence
   property p_lag;
      s_diff3 |=> s_r.q == $past(raw);
   endproperty
   a_lag: assert property (p_lag) else $error("filter output did not follow after timeout");

   property p_short;
      (s_r.cnt != '0 && raw == s_r.q) |=> ($stable(s_r.q) && s_r.cnt == '0);
   endproperty
   a_short: assert property (p_short) else $error("short pulse passed the filter");
endmodule // sfic_chan

// ---- rtl/sfic_chan_if.sv ----
// Purpose: carries one channel's settings and sample to a detector/filter slice
// Assumes: driven by the top from registered state
// Notes: logic_use selects the pin level instead of the threshold compare
interface sfic_chan_if;
   import sfic_pkg::*;
   logic [CODE_W-1:0] code;
   logic [CODE_W-1:0] uv_th;
   logic [CODE_W-1:0] ov_th;
   logic [HYST_W-1:0] hyst;
   sfic_mode_t mode;
   logic logic_use;
   logic pin;
   logic [CNT_W-1:0] len;
   logic q;
   modport ctl (output code, uv_th, ov_th, hyst, mode, logic_use, pin, len, input q);
   modport chan (input code, uv_th, ov_th, hyst, mode, logic_use, pin, len, output q);
endinterface

// ---- rtl/sfic_pkg.sv ----
// Purpose: shared constants and types for the supply fault input conditioning block
// Assumes: 100 MHz core clock, 32-bit classic Wishbone register access
// Notes: register byte address is four times the register index
package sfic_pkg;
   // channel counts and widths
   localparam int NPRI = 5;
   localparam int NDUAL = 5;
   localparam int NDET = 10;
   localparam int NFILT = 15;
   localparam int CODE_W = 8;
   localparam int HYST_W = 5;
   localparam int CNT_W = 14;
   localparam int RNG_W = 2;
   // timing: figures in microseconds, counts derived from the clock rate
   localparam int CLK_MHZ = 100;
   localparam int FILT_MAX_US = 100;
   localparam int PULSE_MAX_US = 100;
   localparam int FILT_MAX_CYC = FILT_MAX_US * CLK_MHZ;
   localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
   // register indexes
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_FILT = 6'h01;
   localparam logic [5:0] IDX_PULSE = 6'h02;
   localparam logic [5:0] IDX_STAT = 6'h03;
   localparam logic [5:0] IDX_CH0 = 6'h04;
   // control register fields
   localparam int CTRL_LSEL_LSB = 0;
   localparam int CTRL_EDGE_LSB = 5;
   localparam int CTRL_PDEN_LSB = 10;
   // channel config fields
   localparam int CH_UV_LSB = 0;
   localparam int CH_OV_LSB = 8;
   localparam int CH_HYST_LSB = 16;
   localparam int CH_MODE_LSB = 21;
   localparam int CH_RNG_LSB = 23;
   // status fields
   localparam int STAT_FAULT_LSB = 0;
   localparam int STAT_WARN_LSB = 10;
   localparam int STAT_LOGIC_LSB = 15;
   localparam int STAT_WANY_BIT = 20;
   // writable masks and reset values
   localparam logic [31:0] CTRL_MASK = 32'h0000_7fff;
   localparam logic [31:0] CNT_MASK = 32'h0000_3fff;
   localparam logic [31:0] CH_MASK = 32'h01ff_ffff;
   localparam logic [31:0] CH_VX_MASK = 32'h007f_ffff;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;
   localparam logic [31:0] CH_RST = 32'h0000_ff00;
   // fault detection modes
   typedef enum logic [1:0] {SFIC_MODE_UV, SFIC_MODE_OV, SFIC_MODE_WIN, SFIC_MODE_OFF} sfic_mode_t;
endpackage

// ---- rtl/sfic_top.sv ----
// Purpose: digital conditioning of supply fault detectors and dual-function inputs
// Assumes: sense_code carries each channel's digitised level in its range's code units
// Notes: channels 0-3 positive inputs, 4 high-voltage input, 5-9 dual-function inputs
//
// Our own choices: the register offsets and the Wishbone slave port.
module sfic_top
   import sfic_pkg::*;
#(
   parameter int FILT_MAX = FILT_MAX_CYC,
   parameter int PULSE_MAX = PULSE_MAX_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NDET*CODE_W-1:0] sense_code,
   input wire logic [NDUAL-1:0] vx_pin,
   output logic [NDET-1:0] fault_o,
   output logic [NDUAL-1:0] warn_o,
   output logic warn_any_o,
   output logic [NDUAL-1:0] logic_o,
   output logic [NDUAL-1:0] pulldown_en_o,
   output logic [NPRI*RNG_W-1:0] range_sel_o
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] flen;
      logic [31:0] plen;
      logic [NDET-1:0][31:0] chcfg;
      logic [NDET-1:0][CODE_W-1:0] c1;
      logic [NDET-1:0][CODE_W-1:0] c2;
      logic [NDET-1:0][CODE_W-1:0] c3;
      logic [NDET-1:0][CODE_W-1:0] code;
      logic [NDUAL-1:0] p1;
      logic [NDUAL-1:0] p2;
      logic [NDUAL-1:0] p3;
      logic [NDUAL-1:0] pin;
      logic [NDUAL-1:0] lv_q;
      logic [NDUAL-1:0][CNT_W-1:0] pcnt;
      logic [NDUAL-1:0] lout;
      logic [NDET-1:0] fault;
      logic [NDUAL-1:0] warn;
      logic warn_any;
      logic [NDUAL-1:0] pden;
      logic ack;
      logic [31:0] dat;
   } sfic_st_t;

   sfic_st_t s_r, s_nxt;
   logic [NFILT-1:0] filt_q;
   logic [NDUAL-1:0] lsel;
   logic [NDUAL-1:0] edge_m;
   logic [NDUAL-1:0] lv;
   logic [5:0] idx;
   logic req;

   localparam logic [31:0] FILT_CAP = 32'(FILT_MAX);
   localparam logic [31:0] PULSE_CAP = 32'(PULSE_MAX);

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel, input logic [31:0] msk);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r & msk;
   endfunction

   // clamp a programmed count to its ceiling
   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] cap);
      return (v > cap) ? cap : v;
   endfunction

   sfic_chan_if chan_if[NFILT] ();

   assign lsel = s_r.ctrl[CTRL_LSEL_LSB +: NDUAL];
   assign edge_m = s_r.ctrl[CTRL_EDGE_LSB +: NDUAL];
   assign idx = wb_adr_i[7:2];
   assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;

   // detector and logic slices
   generate
      for (genvar i = 0; i < NFILT; i++) begin : g_ch
         if (i < NDET) begin : g_det
            localparam int P = (i >= NPRI) ? i - NPRI : i;
            // dual channel in logic use watches its mapped primary input
            assign chan_if[i].code = (i >= NPRI && lsel[P]) ? s_r.code[P] : s_r.code[i];
            assign chan_if[i].uv_th = s_r.chcfg[i][CH_UV_LSB +: CODE_W];
            assign chan_if[i].ov_th = s_r.chcfg[i][CH_OV_LSB +: CODE_W];
            assign chan_if[i].hyst = s_r.chcfg[i][CH_HYST_LSB +: HYST_W];
            assign chan_if[i].mode = sfic_mode_t'(s_r.chcfg[i][CH_MODE_LSB +: 2]);
            assign chan_if[i].logic_use = 1'b0;
            assign chan_if[i].pin = 1'b0;
         end else begin : g_log
            assign chan_if[i].code = '0;
            assign chan_if[i].uv_th = '0;
            assign chan_if[i].ov_th = '0;
            assign chan_if[i].hyst = '0;
            assign chan_if[i].mode = SFIC_MODE_OFF;
            assign chan_if[i].logic_use = 1'b1;
            assign chan_if[i].pin = s_r.pin[i-NDET];
         end
         assign chan_if[i].len = s_r.flen[CNT_W-1:0];
         assign filt_q[i] = chan_if[i].q;
         sfic_chan u_chan (
            .clk(clk),
            .rstn(rstn),
            .ch(chan_if[i])
         );
      end
   endgenerate

   // analog selection removes the logic input
   assign lv = filt_q[NFILT-1:NDET] & lsel;

   // synchronisers, registers, bus and outputs
   always_comb begin
      s_nxt = s_r;
      s_nxt.c1 = sense_code;
      s_nxt.c2 = s_r.c1;
      s_nxt.c3 = s_r.c2;
      for (int i = 0; i < NDET; i++) begin
         if (s_r.c2[i] == s_r.c3[i]) begin
            s_nxt.code[i] = s_r.c3[i];
         end
      end
      s_nxt.p1 = vx_pin;
      s_nxt.p2 = s_r.p1;
      s_nxt.p3 = s_r.p2;
      for (int j = 0; j < NDUAL; j++) begin
         if (s_r.p2[j] == s_r.p3[j]) begin
            s_nxt.pin[j] = s_r.p3[j];
         end
      end
      // register bus: ack one cycle after the request
      s_nxt.ack = req;
      s_nxt.dat = '0;
      if (req && wb_we_i) begin
         case (idx)
            IDX_CTRL: s_nxt.ctrl = wr_merge(s_r.ctrl, wb_dat_i, wb_sel_i, CTRL_MASK);
            IDX_FILT: s_nxt.flen = clamp(wr_merge(s_r.flen, wb_dat_i, wb_sel_i, CNT_MASK),
                                         FILT_CAP);
            IDX_PULSE: s_nxt.plen = clamp(wr_merge(s_r.plen, wb_dat_i, wb_sel_i, CNT_MASK),
                                          PULSE_CAP);
            default: begin
               for (int i = 0; i < NDET; i++) begin
                  if (idx == IDX_CH0 + 6'(i)) begin
                     // dual inputs carry no range field of their own
                     s_nxt.chcfg[i] = wr_merge(s_r.chcfg[i], wb_dat_i, wb_sel_i,
                                               (i < NPRI) ? CH_MASK : CH_VX_MASK);
                  end
               end
            end
         endcase
      end else if (req) begin
         case (idx)
            IDX_CTRL: s_nxt.dat = s_r.ctrl;
            IDX_FILT: s_nxt.dat = s_r.flen;
            IDX_PULSE: s_nxt.dat = s_r.plen;
            IDX_STAT: begin
               s_nxt.dat[STAT_FAULT_LSB +: NDET] = s_r.fault;
               s_nxt.dat[STAT_WARN_LSB +: NDUAL] = s_r.warn;
               s_nxt.dat[STAT_LOGIC_LSB +: NDUAL] = s_r.lout;
               s_nxt.dat[STAT_WANY_BIT] = s_r.warn_any;
            end
            default: begin
               for (int i = 0; i < NDET; i++) begin
                  if (idx == IDX_CH0 + 6'(i)) begin
                     s_nxt.dat = s_r.chcfg[i];
                     // warning detector reports the range of its primary
                     if (i >= NPRI && lsel[i-NPRI]) begin
                        s_nxt.dat[CH_RNG_LSB +: RNG_W] =
                           s_r.chcfg[i-NPRI][CH_RNG_LSB +: RNG_W];
                     end
                  end
               end
            end
         endcase
      end
      // fault and warning outputs
      s_nxt.fault[NPRI-1:0] = filt_q[NPRI-1:0];
      s_nxt.fault[NDET-1:NPRI] = filt_q[NDET-1:NPRI] & ~lsel;
      s_nxt.warn = filt_q[NDET-1:NPRI] & lsel;
      s_nxt.warn_any = |s_nxt.warn;
      s_nxt.pden = s_r.ctrl[CTRL_PDEN_LSB +: NDUAL] & lsel;
      // logic outputs: level copy or timed edge pulse
      s_nxt.lv_q = lv;
      for (int j = 0; j < NDUAL; j++) begin
         if (!edge_m[j]) begin
            s_nxt.lout[j] = lv[j];
            s_nxt.pcnt[j] = '0;
         end else if (lv[j] != s_r.lv_q[j]) begin
            s_nxt.lout[j] = 1'b1;
            s_nxt.pcnt[j] = (s_r.plen[CNT_W-1:0] == '0) ? '0 : s_r.plen[CNT_W-1:0] - 14'h0001;
         end else if (s_r.pcnt[j] != '0) begin
            s_nxt.pcnt[j] = s_r.pcnt[j] - 14'h0001;
         end else begin
            s_nxt.lout[j] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
         s_r.flen <= CNT_RST;
         s_r.plen <= CNT_RST;
         s_r.chcfg <= {NDET{CH_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign fault_o = s_r.fault;
   assign warn_o = s_r.warn;
   assign warn_any_o = s_r.warn_any;
   assign logic_o = s_r.lout;
   assign pulldown_en_o = s_r.pden;
   generate
      for (genvar k = 0; k < NPRI; k++) begin : g_rng
         assign range_sel_o[k*RNG_W +: RNG_W] = s_r.chcfg[k][CH_RNG_LSB +: RNG_W];
      end
   endgenerate

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_vx_excl;
      (fault_o[NDET-1:NPRI] & $past(lsel)) == '0;
   endproperty
   a_vx_excl: assert property (p_vx_excl) else $error("logic-use input reported a fault");

   property p_warn_map;
      warn_o == ($past(filt_q[NDET-1:NPRI]) & $past(lsel));
   endproperty
   a_warn_map: assert property (p_warn_map) else $error("warning not from mapped detector");

   property p_warn_any;
      warn_any_o == |warn_o;
   endproperty
   a_warn_any: assert property (p_warn_any) else $error("combined warning mismatch");

   property p_pd;
      (pulldown_en_o & ~$past(lsel)) == '0;
   endproperty
   a_pd: assert property (p_pd) else $error("pull-down on analog input");

   property p_level;
      (lsel[0] && !edge_m[0]) |=> logic_o[0] == $past(filt_q[NDET]);
   endproperty
   a_level: assert property (p_level) else $error("level mode not a copy");

   sequence s_edge0;
      edge_m[0] && (lv[0] != s_r.lv_q[0]) && s_r.plen == 32'd3;
   endsequence
   property p_edge;
      s_edge0 ##1 (edge_m[0] && lv[0] == s_r.lv_q[0])[*3] |-> logic_o[0] ##1 !logic_o[0];
   endproperty
   a_edge: assert property (p_edge) else $error("edge pulse width wrong");

   property p_fcap;
      s_r.flen <= FILT_CAP && s_r.plen <= PULSE_CAP;
   endproperty
   a_fcap: assert property (p_fcap) else $error("count above ceiling");
endmodule // sfic_top
